//--- hdl/supervisor_pkg.sv
// Constants for the supply supervisor and watchdog block.
// Assumes a single 125 MHz clock; all analogue comparators arrive as digital levels.
package supervisor_pkg;

   // ---------------------------------------------------------------
   // Clock and counter sizing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_KHZ   = 125000;
   localparam int unsigned CLK_MHZ   = 125;
   localparam int unsigned CNT_W     = 27;

   // ---------------------------------------------------------------
   // Times in their own units and derived cycle counts
   // ---------------------------------------------------------------
   localparam int unsigned RESET_HOLD_MS  = 150;
   localparam int unsigned WDOG_SHORT_MS  = 150;
   localparam int unsigned WDOG_MID_MS    = 400;
   localparam int unsigned WDOG_LONG_MS   = 800;
   localparam int unsigned DEBOUNCE_MS    = 10;
   localparam int unsigned LOWLINE_DLY_NS = 200;

   localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CLK_KHZ;
   localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_MS * CLK_KHZ;
   localparam int unsigned WDOG_MID_CYC   = WDOG_MID_MS * CLK_KHZ;
   localparam int unsigned WDOG_LONG_CYC  = WDOG_LONG_MS * CLK_KHZ;
   localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
   // Least time: round up to whole cycles
   localparam int unsigned LOWLINE_DLY_CYC = (LOWLINE_DLY_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // Period select encodings {hi, lo} and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_SHORT   = 2'h2;
   localparam logic [1:0] SEL_MID     = 2'h1;
   localparam logic [1:0] SEL_LONG    = 2'h0;
   localparam logic [1:0] SEL_OFF     = 2'h3;
   localparam logic [1:0] SEL_RESET   = SEL_OFF;

   // ---------------------------------------------------------------
   // Supervisor states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HOLD  = 3'h1,
      ST_RUN   = 3'h2,
      ST_DELAY = 3'h4
   } sup_state_e;

endpackage : supervisor_pkg

//--- hdl/supply_supervisor_watchdog.sv
// Supply supervisor: reset generation, second supply monitor, supply selector and watchdog.
// Assumes all inputs synchronous to clk; comparator results come in as levels.
// Function
// [R1] Watchdog period from select bits: 10=150ms, 01=400ms, 00=800ms.
// [R2] Select bits both one disable the watchdog and hold the fault inactive.
// [R3] After power-up reset stays asserted until main supply is good for hold period.
// [R4] Main supply drop asserts reset; release only after hold period of good supply.
// [R5] Serial bus activity is ignored while main supply is below trip.
// [R6] Second supply fail output follows the second monitor input.
// [R7] Second monitor not evaluated when both main and backup are at or below trip.
// [R8] Start then first falling clock edge restarts watchdog; expiry drives the fault.
// [R9] Start is data falling while clock high; no command is framed before one.
// [R10] Period bits are non-volatile; host writes change them and they persist.
// [R11] Factory value of the period bits disables the watchdog.
// [R12] Backup mode stops and clears the watchdog count; resumes when mains return.
// [R13] Below trip, selector takes mains above battery+30mV, battery below battery-30mV.
// [R14] Mains-selected status output is low while mains feeds the switched output.
// [R15] Mains below trip and below battery: backup mode, reset held, no communication.
// [R16] Manual reset low asserts reset, held for hold period after release.
// [R17] Manual reset input is debounced internally.
// [R18] Reset assertion follows low-supply indication by a short delay on power-down.
`timescale 1ns/100ps
`default_nettype none

module supply_supervisor_watchdog #(
   parameter int unsigned HOLD_CYC  = supervisor_pkg::RESET_HOLD_CYC,
   parameter int unsigned SHORT_CYC = supervisor_pkg::WDOG_SHORT_CYC,
   parameter int unsigned MID_CYC   = supervisor_pkg::WDOG_MID_CYC,
   parameter int unsigned LONG_CYC  = supervisor_pkg::WDOG_LONG_CYC,
   parameter int unsigned DEB_CYC   = supervisor_pkg::DEBOUNCE_CYC
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic main_monitor_in,
   input  wire logic backup_supply_ok,
   input  wire logic mains_above_batt,
   input  wire logic mains_below_batt,
   input  wire logic second_monitor_in,
   input  wire logic manual_reset_n,
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic nv_sel_hi,
   input  wire logic nv_sel_lo,
   input  wire logic period_wr,
   input  wire logic period_wr_hi,
   input  wire logic period_wr_lo,
   output var  logic reset_n,
   output var  logic second_supply_fail_n,
   output var  logic watchdog_fault_n,
   output var  logic mains_selected_n,
   output var  logic backup_mode,
   output var  logic frame_active,
   output var  logic wdog_period_sel_hi,
   output var  logic wdog_period_sel_lo
);

   localparam int unsigned W = supervisor_pkg::CNT_W;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   supervisor_pkg::sup_state_e st;
   supervisor_pkg::sup_state_e next_st;
   logic [W-1:0] hold_cnt;
   logic [W-1:0] lr_cnt;
   logic [W-1:0] deb_cnt;
   logic [W-1:0] wd_cnt;
   logic         mr_clean;
   logic         sel_mains;
   logic         next_sel;
   logic         backup;
   logic         main_ok;
   logic         v2_eval;
   logic         scl_q;
   logic         sda_q;
   logic         start;
   logic         stop;
   logic         armed;
   logic         kick;
   logic         loaded;
   logic [1:0]   sel;
   logic         wd_on;

   // Period lookup shared by the counter and its checks
   function automatic logic [W-1:0] wdog_limit(input logic [1:0] s);
      logic [W-1:0] r;
      r = W'(LONG_CYC - 1);
      unique case (s)
         supervisor_pkg::SEL_SHORT: r = W'(SHORT_CYC - 1);
         supervisor_pkg::SEL_MID:   r = W'(MID_CYC - 1);
         supervisor_pkg::SEL_LONG:  r = W'(LONG_CYC - 1);
         supervisor_pkg::SEL_OFF:   r = W'(LONG_CYC - 1);
      endcase
      return r;
   endfunction : wdog_limit

   assign main_ok = main_monitor_in;
   assign sel     = {wdog_period_sel_hi, wdog_period_sel_lo};
   assign wd_on   = (sel != supervisor_pkg::SEL_OFF);
   assign v2_eval = main_ok | backup_supply_ok;

   // ---------------------------------------------------------------
   // Manual reset debounce
   // ---------------------------------------------------------------
   // A change must persist for the whole window before it is accepted
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mr_clean <= 1'b1;
         deb_cnt  <= '0;
      end else if (manual_reset_n == mr_clean) begin
         deb_cnt <= '0;
      end else if (deb_cnt == W'(DEB_CYC - 1)) begin
         mr_clean <= manual_reset_n;  // R17
         deb_cnt  <= '0;
      end else begin
         deb_cnt <= deb_cnt + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Supply selector
   // ---------------------------------------------------------------
   // Between the two thresholds the previous choice is kept, giving hysteresis
   always_comb begin
      next_sel = sel_mains;
      if (main_ok)
         next_sel = 1'b1;
      else if (mains_above_batt)
         next_sel = 1'b1;  // R13
      else if (mains_below_batt)
         next_sel = 1'b0;  // R13
   end

   assign backup = !main_ok && !next_sel;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_mains        <= 1'b1;
         mains_selected_n <= 1'b0;
         backup_mode      <= 1'b0;
      end else begin
         sel_mains        <= next_sel;
         mains_selected_n <= !next_sel;  // R14
         backup_mode      <= backup;     // R15
      end
   end

   // ---------------------------------------------------------------
   // Reset state machine
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      unique case (st)
         supervisor_pkg::ST_HOLD: begin
            if (main_ok && mr_clean && hold_cnt == W'(HOLD_CYC - 1))
               next_st = supervisor_pkg::ST_RUN;  // R3 R4 R16
         end
         supervisor_pkg::ST_RUN: begin
            if (!mr_clean)
               next_st = supervisor_pkg::ST_HOLD;  // R16
            else if (!main_ok)
               next_st = supervisor_pkg::ST_DELAY;  // R4
         end
         supervisor_pkg::ST_DELAY: begin
            if (!mr_clean || lr_cnt == W'(supervisor_pkg::LOWLINE_DLY_CYC - 1))
               next_st = supervisor_pkg::ST_HOLD;  // R18
         end
         default: next_st = supervisor_pkg::ST_HOLD;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st      <= supervisor_pkg::ST_HOLD;
         reset_n <= 1'b0;  // R3
      end else begin
         st      <= next_st;
         reset_n <= (next_st != supervisor_pkg::ST_HOLD);
      end
   end

   // Hold count restarts on any dip so the full period follows the last good edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         hold_cnt <= '0;
      else if (st != supervisor_pkg::ST_HOLD || !main_ok || !mr_clean)
         hold_cnt <= '0;  // R4
      else if (hold_cnt != W'(HOLD_CYC - 1))
         hold_cnt <= hold_cnt + 1'b1;  // R3
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         lr_cnt <= '0;
      else if (st == supervisor_pkg::ST_DELAY)
         lr_cnt <= lr_cnt + 1'b1;  // R18
      else
         lr_cnt <= '0;
   end

   // ---------------------------------------------------------------
   // Second supply monitor
   // ---------------------------------------------------------------
   // Unpowered comparator: the last valid answer is kept
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         second_supply_fail_n <= 1'b0;
      else if (v2_eval)  // R7
         second_supply_fail_n <= second_monitor_in;  // R6
   end

   // ---------------------------------------------------------------
   // Serial bus start and stop detection
   // ---------------------------------------------------------------
   assign start = main_ok && scl_in && scl_q && sda_q && !sda_in;  // R9 R5
   assign stop  = scl_in && scl_q && !sda_q && sda_in;
   assign kick  = armed && scl_q && !scl_in && main_ok;  // R8

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         armed <= 1'b0;
      else if (!main_ok || kick)
         armed <= 1'b0;  // R5
      else if (start)
         armed <= 1'b1;  // R9
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         frame_active <= 1'b0;
      else if (!main_ok || stop)
         frame_active <= 1'b0;  // R5 R15
      else if (start)
         frame_active <= 1'b1;  // R9
   end

   // ---------------------------------------------------------------
   // Period select bits
   // ---------------------------------------------------------------
   // The outside store is read once after reset release, then written back through the outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         loaded             <= 1'b0;
         wdog_period_sel_hi <= supervisor_pkg::SEL_RESET[1];  // R11
         wdog_period_sel_lo <= supervisor_pkg::SEL_RESET[0];  // R11
      end else if (!loaded) begin
         loaded             <= 1'b1;
         wdog_period_sel_hi <= nv_sel_hi;  // R10
         wdog_period_sel_lo <= nv_sel_lo;  // R10
      end else if (period_wr && main_ok) begin
         wdog_period_sel_hi <= period_wr_hi;  // R10
         wdog_period_sel_lo <= period_wr_lo;  // R10
      end
   end

   // ---------------------------------------------------------------
   // Watchdog counter
   // ---------------------------------------------------------------
   // Fault stays until the next restart or until the select bits switch the watchdog off; a period change takes effect on the next count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wd_cnt           <= '0;
         watchdog_fault_n <= 1'b1;
      end else if (!wd_on) begin
         wd_cnt           <= '0;
         watchdog_fault_n <= 1'b1;  // R2
      end else if (backup) begin
         wd_cnt <= '0;  // R12
      end else if (kick) begin
         wd_cnt           <= '0;  // R8
         watchdog_fault_n <= 1'b1;
      end else if (wd_cnt >= wdog_limit(sel)) begin
         watchdog_fault_n <= 1'b0;  // R1 R8
      end else begin
         wd_cnt <= wd_cnt + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   localparam int LR_MAX = 30;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_lowline;
      st == supervisor_pkg::ST_RUN && !main_ok && mr_clean;
   endsequence

   sequence s_mr_stays;
      mr_clean [*2];
   endsequence

   a_mr_forces_reset: assert property (!mr_clean |=> !reset_n)  // R16
      else $error("manual reset did not assert reset");
   a_hold_release: assert property ($rose(reset_n) |-> $past(hold_cnt) == W'(HOLD_CYC - 1))  // R3
      else $error("reset released before hold period");
   a_lowline_delay: assert property (s_lowline ##0 s_mr_stays |=> reset_n)  // R18
      else $error("reset asserted without delay");
   a_lowline_reset: assert property (s_lowline |-> ##[1:LR_MAX] !reset_n)  // R4
      else $error("low supply did not assert reset");
   a_bus_gated: assert property (!main_ok |=> !frame_active && !armed)  // R5
      else $error("bus activity accepted on low supply");
   a_start_frames: assert property (start |=> frame_active)  // R9
      else $error("start condition not recognised");
   a_v2_tracks: assert property (v2_eval |=> second_supply_fail_n == $past(second_monitor_in))  // R6
      else $error("second fail output does not follow input");
   a_v2_frozen: assert property (!v2_eval |=> $stable(second_supply_fail_n))  // R7
      else $error("second monitor evaluated without power");
   a_wd_off: assert property (!wd_on |=> watchdog_fault_n && wd_cnt == '0)  // R2
      else $error("disabled watchdog active");
   a_wd_kick: assert property (kick && wd_on && !backup |=> wd_cnt == '0 && watchdog_fault_n)  // R8
      else $error("restart did not clear watchdog");
   a_wd_expire: assert property (wd_on && !backup && !kick && wd_cnt == wdog_limit(sel)
                                 |=> !watchdog_fault_n)  // R1
      else $error("watchdog did not fault at period end");
   a_backup_clear: assert property (backup |=> wd_cnt == '0)  // R12
      else $error("watchdog count kept in backup mode");
   a_backup_reset: assert property (backup |-> ##[0:LR_MAX] !reset_n)  // R15
      else $error("reset not asserted in backup mode");
   a_sel_mains: assert property (main_ok |=> !mains_selected_n)  // R13 R14
      else $error("mains not selected above trip");
   a_sel_batt: assert property (!main_ok && !mains_above_batt && mains_below_batt
                                |=> mains_selected_n && backup_mode)  // R13 R15
      else $error("battery not selected");

endmodule : supply_supervisor_watchdog

`default_nettype wire

//--- verif/bus_host_model.sv
// Host model: drives the two-wire bus levels and the period write strobe.
// Assumes its tasks are called from one process, one at a time.
`timescale 1ns/100ps
`default_nettype none

module bus_host_model (
   input  wire logic clk,
   output var  logic scl,
   output var  logic sda,
   output var  logic period_wr,
   output var  logic period_wr_hi,
   output var  logic period_wr_lo
);
   // ---------------------------------------------------------------
   // Bus idles high on its pull-ups
   // ---------------------------------------------------------------
   initial begin
      scl          = 1'b1;
      sda          = 1'b1;
      period_wr    = 1'b0;
      period_wr_hi = 1'b0;
      period_wr_lo = 1'b0;
   end

   task automatic step(input logic c, input logic d);
      @(posedge clk);
      scl <= c;
      sda <= d;
   endtask : step

   // Start, then the clock fall that restarts the count
   task automatic restart();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : restart

   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop

   // Data moves only while the clock is low, so no start is framed
   task automatic no_start();
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : no_start

   // Data is inverted outside the strobe so stale values never pass
   task automatic write_sel(input logic [1:0] sel);
      @(posedge clk);
      period_wr    <= 1'b1;
      period_wr_hi <= sel[1];
      period_wr_lo <= sel[0];
      @(posedge clk);
      period_wr    <= 1'b0;
      period_wr_hi <= ~sel[1];
      period_wr_lo <= ~sel[0];
   endtask : write_sel
endmodule : bus_host_model
`default_nettype wire

//--- verif/supply_supervisor_watchdog_tb.sv
// Self-checking bench for the supply supervisor and watchdog.
// Assumes shortened counts by parameter; the host model drives the bus.
`timescale 1ns/100ps
`default_nettype none

module supply_supervisor_watchdog_tb;
   // ---------------------------------------------------------------
   // Short counts keep the run brief
   // ---------------------------------------------------------------
   localparam int H = 20;
   localparam int S = 40;
   localparam int M = 60;
   localparam int L = 80;
   localparam int D = 4;
   logic clk = 1'b0, rstn = 1'b0, main_monitor_in = 1'b1, backup_supply_ok = 1'b1;
   logic mains_above_batt = 1'b1, mains_below_batt = 1'b0, second_monitor_in = 1'b1;
   logic manual_reset_n = 1'b1, nv_sel_hi = 1'b1, nv_sel_lo = 1'b1;
   logic scl, sda, period_wr, period_wr_hi, period_wr_lo, sel_hi, sel_lo;
   logic reset_n, second_supply_fail_n, watchdog_fault_n, mains_selected_n, backup_mode, frame_active;
   int   errors = 0, compares = 0, cycles = 0;

   always #4 clk = ~clk;

   supply_supervisor_watchdog #(.HOLD_CYC(H), .SHORT_CYC(S), .MID_CYC(M), .LONG_CYC(L), .DEB_CYC(D)) uut (
      .clk(clk), .rstn(rstn), .main_monitor_in(main_monitor_in), .backup_supply_ok(backup_supply_ok),
      .mains_above_batt(mains_above_batt), .mains_below_batt(mains_below_batt),
      .second_monitor_in(second_monitor_in), .manual_reset_n(manual_reset_n), .scl_in(scl), .sda_in(sda),
      .nv_sel_hi(nv_sel_hi), .nv_sel_lo(nv_sel_lo), .period_wr(period_wr), .period_wr_hi(period_wr_hi),
      .period_wr_lo(period_wr_lo), .reset_n(reset_n), .second_supply_fail_n(second_supply_fail_n),
      .watchdog_fault_n(watchdog_fault_n), .mains_selected_n(mains_selected_n), .backup_mode(backup_mode),
      .frame_active(frame_active), .wdog_period_sel_hi(sel_hi), .wdog_period_sel_lo(sel_lo));

   bus_host_model host (.clk(clk), .scl(scl), .sda(sda), .period_wr(period_wr),
      .period_wr_hi(period_wr_hi), .period_wr_lo(period_wr_lo));

   // ---------------------------------------------------------------
   // Checks and helpers
   // ---------------------------------------------------------------
   task automatic check_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s got %b exp %b", $time, what, got, exp);
      end
   endtask : check_bit

   task automatic check_range(input int got, input int lo, input int hi, input string what);
      compares++;
      if (got < lo || got > hi) begin
         errors++;
         $display("MISMATCH at %0t: %s took %0d, not %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : check_range

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   // Bounded wait for reset_n (0) or the fault output (1) to reach a level
   task automatic wait_for(input int which, input logic lvl, output int n);
      logic v;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         v = (which == 0) ? reset_n : watchdog_fault_n;
      end while (v !== lvl && n < 500);
   endtask : wait_for

   task automatic drive_main(input logic m, input logic above, input logic below);
      @(posedge clk);
      main_monitor_in  <= m;
      mains_above_batt <= above;
      mains_below_batt <= below;
   endtask : drive_main

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_power_up();
      int n;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check_bit(reset_n, 1'b0, "reset during power-up");
      check_bit(sel_hi & sel_lo, 1'b1, "period bits held off in reset");
      @(posedge clk);
      rstn <= 1'b1;
      wait_for(0, 1'b1, n);
      check_range(n, H, H + 3, "power-up release");
      check_bit(sel_hi & sel_lo, 1'b1, "factory period bits");
      check_bit(mains_selected_n, 1'b0, "mains feeds output");
      check_bit(second_supply_fail_n, 1'b1, "second supply good");
      cyc(L + 10);
      check_bit(watchdog_fault_n, 1'b1, "disabled watchdog");
   endtask : t_power_up

   task automatic t_periods();
      logic [1:0] sel [3] = '{2'h2, 2'h1, 2'h0};
      int         lim [3] = '{S, M, L};
      int         n;
      for (int i = 0; i < 3; i++) begin
         host.write_sel(sel[i]);
         cyc(2);
         check_bit(sel_hi, sel[i][1], "period bit hi");
         check_bit(sel_lo, sel[i][0], "period bit lo");
         host.restart();
         wait_for(1, 1'b0, n);
         check_range(n, lim[i] - 1, lim[i] + 3, "watchdog period");
         check_bit(frame_active, 1'b1, "frame after start");
         host.restart();
         cyc(2);
         check_bit(watchdog_fault_n, 1'b1, "fault cleared by restart");
         host.stop();
         cyc(2);
         check_bit(frame_active, 1'b0, "frame ends at stop");
      end
   endtask : t_periods

   task automatic t_no_start();
      int n;
      host.restart();
      host.stop();
      cyc(27);
      host.no_start();
      wait_for(1, 1'b0, n);
      check_range(n, L - 36, L - 29, "no restart without start");
      check_bit(frame_active, 1'b0, "no frame without start");
      host.restart();
      host.stop();
   endtask : t_no_start

   task automatic t_keepalive();
      for (int i = 0; i < 4; i++) begin
         cyc(L / 2);
         host.restart();
         host.stop();
         check_bit(watchdog_fault_n, 1'b1, "kept alive");
      end
   endtask : t_keepalive

   // A dip of the main supply during the hold restarts the count
   task automatic t_brownout();
      int n;
      drive_main(1'b0, 1'b1, 1'b0);
      wait_for(0, 1'b0, n);
      check_range(n, 13, 37, "reset after supply drop");
      host.restart();
      host.stop();
      host.write_sel(2'h2);
      cyc(2);
      check_bit(frame_active, 1'b0, "bus ignored when low");
      check_bit(sel_hi, 1'b0, "write ignored when low");
      check_bit(mains_selected_n, 1'b0, "mains above battery");
      drive_main(1'b1, 1'b1, 1'b0);
      cyc(H / 2);
      drive_main(1'b0, 1'b1, 1'b0);
      drive_main(1'b1, 1'b1, 1'b0);
      wait_for(0, 1'b1, n);
      check_range(n, H, H + 3, "release after dip");
   endtask : t_brownout

   task automatic t_backup();
      int n;
      host.restart();
      host.stop();
      cyc(L / 2);
      drive_main(1'b0, 1'b0, 1'b1);
      cyc(40);
      check_bit(mains_selected_n, 1'b1, "battery feeds output");
      check_bit(backup_mode, 1'b1, "backup mode");
      check_bit(reset_n, 1'b0, "reset in backup");
      cyc(L);
      check_bit(watchdog_fault_n, 1'b1, "no expiry in backup");
      drive_main(1'b0, 1'b0, 1'b0);
      host.restart();
      cyc(2);
      check_bit(mains_selected_n, 1'b1, "selector holds");
      check_bit(frame_active, 1'b0, "no bus in backup");
      drive_main(1'b1, 1'b1, 1'b0);
      wait_for(1, 1'b0, n);
      check_range(n, L - 2, L + 4, "count cleared in backup");
      check_bit(mains_selected_n, 1'b0, "mains back");
      check_bit(backup_mode, 1'b0, "backup left");
      host.stop();
   endtask : t_backup

   task automatic t_second();
      @(posedge clk);
      second_monitor_in <= 1'b0;
      cyc(3);
      check_bit(second_supply_fail_n, 1'b0, "second supply low");
      @(posedge clk);
      second_monitor_in <= 1'b1;
      cyc(3);
      check_bit(second_supply_fail_n, 1'b1, "second supply back");
      @(posedge clk);
      backup_supply_ok  <= 1'b0;
      main_monitor_in   <= 1'b0;
      second_monitor_in <= 1'b0;
      cyc(3);
      check_bit(second_supply_fail_n, 1'b1, "monitor frozen");
      @(posedge clk);
      backup_supply_ok <= 1'b1;
      main_monitor_in  <= 1'b1;
      cyc(3);
      check_bit(second_supply_fail_n, 1'b0, "monitor resumes");
      @(posedge clk);
      second_monitor_in <= 1'b1;
   endtask : t_second

   task automatic t_manual();
      int n;
      wait_for(0, 1'b1, n);
      @(posedge clk);
      manual_reset_n <= 1'b0;
      cyc(2);
      @(posedge clk);
      manual_reset_n <= 1'b1;
      cyc(10);
      check_bit(reset_n, 1'b1, "glitch ignored");
      @(posedge clk);
      manual_reset_n <= 1'b0;
      wait_for(0, 1'b0, n);
      check_range(n, D, D + 3, "manual reset");
      cyc(30);
      check_bit(reset_n, 1'b0, "held while pressed");
      @(posedge clk);
      manual_reset_n <= 1'b1;
      wait_for(0, 1'b1, n);
      check_range(n, D + H, D + H + 4, "hold after release");
   endtask : t_manual

   // A second power cycle must bring back the stored period, not the off value
   task automatic t_persist();
      int n;
      @(posedge clk);
      rstn      <= 1'b0;
      nv_sel_hi <= 1'b0;
      nv_sel_lo <= 1'b1;
      cyc(2);
      check_bit(sel_hi & sel_lo, 1'b1, "period bits off in reset");
      check_bit(reset_n, 1'b0, "reset during power cycle");
      @(posedge clk);
      rstn <= 1'b1;
      wait_for(0, 1'b1, n);
      check_range(n, H, H + 3, "release after power cycle");
      check_bit(sel_hi, 1'b0, "stored period bit hi");
      check_bit(sel_lo, 1'b1, "stored period bit lo");
   endtask : t_persist

   // ---------------------------------------------------------------
   // Verdict, watchdog of the run, main sequence
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("Counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // Whole run needs about 1100 cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         give_verdict();
      end
   end

   initial begin
      t_power_up();
      $display("power-up test ended");
      t_periods();
      $display("period test ended");
      t_no_start();
      $display("start framing test ended");
      t_keepalive();
      $display("keepalive test ended");
      t_brownout();
      $display("brownout test ended");
      t_backup();
      $display("backup test ended");
      t_second();
      $display("second supply test ended");
      t_manual();
      $display("manual reset test ended");
      t_persist();
      $display("power cycle test ended");
      give_verdict();
   end
endmodule : supply_supervisor_watchdog_tb
`default_nettype wire
